//--- src/exs_seq.sv
/*
  exception entry sequencer: saves the status word, enters supervisor
  state, finds the vector, pushes the two-longword frame and fetches the
  handler address, then issues the first handler fetch.
  assumes a single-outstanding bus with a one-cycle done strobe, and that
  the core holds exc_req until exc_ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "exs_regs.svh"

// What this block does
// - keep status copy, then set supervisor, clear trace
// - interrupts also clear master flag and set mask to level
// - non-interrupt vectors come from the exception type, no bus cycle
// - interrupts run an acknowledge cycle with level in address
// - frame goes on the one stack pointer, aligned down to four
// - frame is two longwords: format/vector plus status, then pc
// - handler address read at table base plus four times vector
// - finish once the handler's first opcode fetch completes
// - table holds 256 vectors; 64 architectural, 192 user interrupts
// - faulting-instruction pc stacked for errors, illegal, privilege, line-a/f, format
// - next-instruction pc stacked for trace, debug, traps, interrupts
// - no interrupt sampling during handler's first instruction
// - format field four to seven from stack pointer low bits
// - fault status only for access and address errors, else zero
// - fault codes: fetch, operand write, protected write, operand read
// - vector field holds internal number or acknowledged number
// - restart model: faulting pc lets the instruction rerun
// - table base uses upper twelve bits, low twenty zero
// - levels at or below mask inhibited, level seven edge excepted
module exs_seq
  import exs_pkg::*;
(
  input wire logic clk_sys, // core clock, 25 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic exc_req, // fault or trap pending
  input wire exs_pkg::exs_cause_t exc_cause, // its cause
  input wire logic [3:0] exc_trap_num, // trap number 0-15
  input wire logic [3:0] exc_fault_code, // raw fault status
  input wire logic [31:0] pc_fault, // pc of faulting instruction
  input wire logic [31:0] pc_next, // pc of next instruction
  input wire logic [15:0] processor_status_word, // live status word
  input wire logic [31:0] system_stack_pointer, // live stack pointer
  input wire logic [31:0] vector_table_base, // table base register
  input wire logic [2:0] irq_pin, // interrupt level from pins
  input wire logic insn_boundary, // core may take an interrupt now
  input wire logic insn_done, // an instruction completed
  input wire logic bus_done, // bus cycle finished
  input wire logic [31:0] bus_rdata, // read data
  output logic exc_ack, // one-cycle: exc_req accepted
  output logic exc_busy, // sequencer in progress
  output logic bus_req, // bus cycle request, held until done
  output exs_pkg::exs_bus_t bus_kind, // cycle kind
  output logic [31:0] bus_addr, // cycle address
  output logic [31:0] bus_wdata, // write data
  output logic psw_we, // one-cycle: load new status word
  output logic [15:0] psw_new, // new status word
  output logic [15:0] psw_saved, // internal copy of status word
  output logic sp_we, // one-cycle: load new stack pointer
  output logic [31:0] sp_new, // handler stack pointer
  output logic pc_we, // one-cycle: handler pc valid
  output logic [31:0] pc_new, // handler pc
  output logic exc_done // one-cycle: first handler fetch completed
);
  exs_state_t state_ff, nxt_state;
  logic [2:0] irq_sync1_ff, irq_sync2_ff;
  logic [15:0] psw_saved_ff;
  logic [7:0] vec_ff;
  logic [3:0] fs_ff;
  logic [31:0] pc_stk_ff;
  logic [31:0] sp_base_ff;
  logic [3:0] fmt_ff;
  logic [31:0] handler_ff;
  logic exc_ack_ff, bus_req_ff, psw_we_ff, sp_we_ff, pc_we_ff, exc_done_ff;
  exs_bus_t bus_kind_ff;
  logic [31:0] bus_addr_ff, bus_wdata_ff, sp_new_ff, pc_new_ff;
  logic [15:0] psw_new_ff;
  logic guard_ff;
  logic busy_ff;

  // interrupt pins come from outside the clock domain
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_sync1_ff <= 3'h0;
      irq_sync2_ff <= 3'h0;
    end else begin
      irq_sync1_ff <= irq_pin;
      irq_sync2_ff <= irq_sync1_ff;
    end
  end

  wire irq_pend;
  wire [2:0] irq_pend_lvl;
  wire idle = (state_ff == EXS_ST_IDLE);
  wire irq_block = !idle || guard_ff || !insn_boundary;
  // an interrupt wins a tie; the fault stays held and is taken afterwards
  wire start_irq = idle && irq_pend && !irq_block;
  wire start_exc = idle && exc_req && !start_irq;
  // end of each bus step except PUSH0, for the captures and strobes below
  wire interrupt_ack_cycle_done = (state_ff == EXS_ST_INTERRUPT_ACK_CYCLE) && bus_done;
  wire push1_done = (state_ff == EXS_ST_PUSH1) && bus_done;
  wire vec_done = (state_ff == EXS_ST_VEC) && bus_done;
  wire fetch_done = (state_ff == EXS_ST_FETCH) && bus_done;

  exs_irq_gate u_irq_gate (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .irq_level(irq_sync2_ff),
    .mask_level(processor_status_word[`EXS_PSW_I_HI:`EXS_PSW_I_LO]),
    .block(irq_block),
    .take(start_irq),
    .pend(irq_pend),
    .pend_level(irq_pend_lvl)
  );

  wire [7:0] trap_vec = `EXS_VEC_TRAP0 | {4'h0, exc_trap_num};
  logic [7:0] int_vec;
  always_comb begin
    case (exc_cause)
      EXS_CAUSE_ACCESS: int_vec = `EXS_VEC_ACCESS;
      EXS_CAUSE_ADDRESS: int_vec = `EXS_VEC_ADDRESS;
      EXS_CAUSE_ILLEGAL: int_vec = `EXS_VEC_ILLEGAL;
      EXS_CAUSE_PRIV: int_vec = `EXS_VEC_PRIV;
      EXS_CAUSE_TRACE: int_vec = `EXS_VEC_TRACE;
      EXS_CAUSE_LINE_A: int_vec = `EXS_VEC_LINE_A;
      EXS_CAUSE_LINE_F: int_vec = `EXS_VEC_LINE_F;
      EXS_CAUSE_DEBUG: int_vec = `EXS_VEC_DEBUG;
      EXS_CAUSE_FORMAT: int_vec = `EXS_VEC_FORMAT;
      default: int_vec = trap_vec;
    endcase
  end

  wire pc_is_fault = (exc_cause == EXS_CAUSE_ACCESS) || (exc_cause == EXS_CAUSE_ADDRESS) ||
                     (exc_cause == EXS_CAUSE_ILLEGAL) || (exc_cause == EXS_CAUSE_PRIV) ||
                     (exc_cause == EXS_CAUSE_LINE_A) || (exc_cause == EXS_CAUSE_LINE_F) ||
                     (exc_cause == EXS_CAUSE_FORMAT);
  wire [31:0] pc_pick = pc_is_fault ? pc_fault : pc_next;

  wire fs_allowed = (exc_cause == EXS_CAUSE_ACCESS) || (exc_cause == EXS_CAUSE_ADDRESS);
  // defined codes pass, reserved ones read as zero
  wire fs_legal = (exc_fault_code == `EXS_FS_IFETCH) || (exc_fault_code == `EXS_FS_OPWRITE) ||
                  (exc_fault_code == `EXS_FS_WPROT) || (exc_fault_code == `EXS_FS_OPREAD);
  wire [3:0] fs_pick = (fs_allowed && fs_legal) ? exc_fault_code : `EXS_FS_NONE;

  // format from stack pointer low bits
  wire [3:0] fmt_pick = `EXS_FMT_BASE | {2'h0, system_stack_pointer[1:0]};
  wire [31:0] sp_align = {system_stack_pointer[31:2], 2'h0};
  wire [31:0] frame_lo = sp_align - `EXS_FRAME_BYTES;

  logic [15:0] psw_enter;
  always_comb begin
    psw_enter = processor_status_word;
    psw_enter[`EXS_PSW_S_BIT] = 1'b1;
    psw_enter[`EXS_PSW_T_BIT] = 1'b0;
    if (start_irq) begin
      psw_enter[`EXS_PSW_M_BIT] = 1'b0;
      psw_enter[`EXS_PSW_I_HI:`EXS_PSW_I_LO] = irq_pend_lvl;
    end
  end

  wire [31:0] interrupt_ack_cycle_addr = `EXS_INTERRUPT_ACK_CYCLE_BASE | ({29'h0, irq_pend_lvl} << `EXS_INTERRUPT_ACK_CYCLE_LVL_LO);
  // first longword: format, fault, vector over status
  wire [31:0] frame_w0 = {fmt_ff, fs_ff, vec_ff, psw_saved_ff};
  // table address, 256 entries of four bytes
  wire [31:0] vec_addr = (vector_table_base & `EXS_VBR_KEEP) | ({24'h0, vec_ff} << `EXS_VEC_SHIFT);

  wire [7:0] ack_vec = bus_rdata[7:0];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EXS_ST_IDLE: begin
        if (start_irq)
          nxt_state = EXS_ST_INTERRUPT_ACK_CYCLE;
        else if (start_exc)
          nxt_state = EXS_ST_PUSH0;
      end
      EXS_ST_INTERRUPT_ACK_CYCLE: if (bus_done) nxt_state = EXS_ST_PUSH0;
      EXS_ST_PUSH0: if (bus_done) nxt_state = EXS_ST_PUSH1;
      EXS_ST_PUSH1: if (bus_done) nxt_state = EXS_ST_VEC;
      EXS_ST_VEC: if (bus_done) nxt_state = EXS_ST_FETCH;
      EXS_ST_FETCH: if (bus_done) nxt_state = EXS_ST_GUARD;
      EXS_ST_GUARD: nxt_state = EXS_ST_IDLE;
      default: nxt_state = EXS_ST_IDLE;
    endcase
  end

  // bus request for the state being entered; held until bus_done
  // the next step's request replaces the last on the done edge, so cycles run back to back
  wire enter_bus = (nxt_state != state_ff) && (nxt_state != EXS_ST_GUARD) && (nxt_state != EXS_ST_IDLE);
  logic [31:0] nxt_addr, nxt_wdata;
  exs_bus_t nxt_kind;
  always_comb begin
    nxt_kind = EXS_BUS_READ;
    nxt_addr = 32'h0000_0000;
    nxt_wdata = 32'h0000_0000;
    case (nxt_state)
      EXS_ST_INTERRUPT_ACK_CYCLE: begin
        nxt_kind = EXS_BUS_INTERRUPT_ACK_CYCLE;
        nxt_addr = interrupt_ack_cycle_addr;
      end
      EXS_ST_PUSH0: begin
        nxt_kind = EXS_BUS_WRITE;
        // lower address holds the first longword
        nxt_addr = idle ? frame_lo : sp_base_ff;
        nxt_wdata = idle ? {fmt_pick, fs_pick, int_vec, processor_status_word}
                         : {fmt_ff, fs_ff, ack_vec, psw_saved_ff};
      end
      EXS_ST_PUSH1: begin
        nxt_kind = EXS_BUS_WRITE;
        nxt_addr = sp_base_ff + 32'h0000_0004;
        nxt_wdata = pc_stk_ff;
      end
      EXS_ST_VEC: begin
        nxt_kind = EXS_BUS_READ;
        nxt_addr = vec_addr;
      end
      EXS_ST_FETCH: begin
        nxt_kind = EXS_BUS_FETCH;
        nxt_addr = bus_rdata;
      end
      default: nxt_kind = EXS_BUS_READ;
    endcase
  end

  // capture of context at entry
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      psw_saved_ff <= 16'h0000;
      vec_ff <= 8'h00;
      fs_ff <= 4'h0;
      pc_stk_ff <= 32'h0000_0000;
      sp_base_ff <= 32'h0000_0000;
      fmt_ff <= 4'h0;
    end else if (start_irq || start_exc) begin
      psw_saved_ff <= processor_status_word;
      // an interrupt's number is unknown until the acknowledge returns it
      vec_ff <= start_irq ? 8'h00 : int_vec;
      fs_ff <= start_irq ? `EXS_FS_NONE : fs_pick;
      pc_stk_ff <= start_irq ? pc_next : pc_pick;
      sp_base_ff <= frame_lo;
      fmt_ff <= fmt_pick;
    end else if (interrupt_ack_cycle_done) begin
      vec_ff <= ack_vec;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= EXS_ST_IDLE;
      busy_ff <= 1'b0;
      bus_req_ff <= 1'b0;
      bus_kind_ff <= EXS_BUS_READ;
      bus_addr_ff <= 32'h0000_0000;
      bus_wdata_ff <= 32'h0000_0000;
      handler_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != EXS_ST_IDLE);
      if (enter_bus) begin
        bus_req_ff <= 1'b1;
        bus_kind_ff <= nxt_kind;
        bus_addr_ff <= nxt_addr;
        bus_wdata_ff <= nxt_wdata;
      end else if (bus_done) begin
        bus_req_ff <= 1'b0;
      end
      if (vec_done)
        handler_ff <= bus_rdata;
    end
  end

  // one-cycle strobes to the core
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      exc_ack_ff <= 1'b0;
      psw_we_ff <= 1'b0;
      psw_new_ff <= 16'h0000;
      sp_we_ff <= 1'b0;
      sp_new_ff <= 32'h0000_0000;
      pc_we_ff <= 1'b0;
      pc_new_ff <= 32'h0000_0000;
      exc_done_ff <= 1'b0;
    end else begin
      exc_ack_ff <= start_exc;
      psw_we_ff <= start_irq || start_exc;
      if (start_irq || start_exc)
        psw_new_ff <= psw_enter;
      // handler stack pointer, 8 to 11 below original
      sp_we_ff <= push1_done;
      if (push1_done)
        sp_new_ff <= sp_base_ff;
      pc_we_ff <= fetch_done;
      exc_done_ff <= fetch_done;
      if (fetch_done)
        pc_new_ff <= handler_ff;
    end
  end

  // limitation: a handler whose first instruction never completes keeps interrupts off
  // guard spans the handler's first instruction
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      guard_ff <= 1'b0;
    else if (state_ff == EXS_ST_GUARD)
      guard_ff <= 1'b1;
    else if (insn_done)
      guard_ff <= 1'b0;
  end

  assign exc_ack = exc_ack_ff;
  assign exc_busy = busy_ff;
  assign bus_req = bus_req_ff;
  assign bus_kind = bus_kind_ff;
  assign bus_addr = bus_addr_ff;
  assign bus_wdata = bus_wdata_ff;
  assign psw_we = psw_we_ff;
  assign psw_new = psw_new_ff;
  assign psw_saved = psw_saved_ff;
  assign sp_we = sp_we_ff;
  assign sp_new = sp_new_ff;
  assign pc_we = pc_we_ff;
  assign pc_new = pc_new_ff;
  assign exc_done = exc_done_ff;
endmodule

`default_nettype wire

//--- src/exs_regs.svh
/*
  constants for the exception entry sequencer: status word fields, frame
  layout, vector numbers, fault status codes and the acknowledge address.
  assumes inclusion once per compile unit through its guard.
*/
`ifndef EXS_REGS_SVH
`define EXS_REGS_SVH

// status word bit positions
`define EXS_PSW_T_BIT 15
`define EXS_PSW_S_BIT 13
`define EXS_PSW_M_BIT 12
`define EXS_PSW_I_HI 10
`define EXS_PSW_I_LO 8

// frame layout
`define EXS_FRAME_BYTES 32'h0000_0008
`define EXS_FMT_BASE 4'h4
`define EXS_VBR_KEEP 32'hFFF0_0000
`define EXS_VEC_SHIFT 2

// architecture vector numbers
`define EXS_VEC_ACCESS 8'h02
`define EXS_VEC_ADDRESS 8'h03
`define EXS_VEC_ILLEGAL 8'h04
`define EXS_VEC_PRIV 8'h08
`define EXS_VEC_TRACE 8'h09
`define EXS_VEC_LINE_A 8'h0A
`define EXS_VEC_LINE_F 8'h0B
`define EXS_VEC_DEBUG 8'h0C
`define EXS_VEC_FORMAT 8'h0E
`define EXS_VEC_TRAP0 8'h20

// fault status codes
`define EXS_FS_NONE 4'h0
`define EXS_FS_IFETCH 4'h4
`define EXS_FS_OPWRITE 4'h8
`define EXS_FS_WPROT 4'h9
`define EXS_FS_OPREAD 4'hC

// acknowledge space address: level sits in bits 4:2
`define EXS_INTERRUPT_ACK_CYCLE_BASE 32'hFFFF_FFE0
`define EXS_INTERRUPT_ACK_CYCLE_LVL_LO 2

`endif

//--- src/exs_pkg.sv
/*
  types for the exception entry sequencer.
  assumes nothing beyond a systemverilog compiler.
*/
package exs_pkg;

  // exception causes presented by the detecting logic
  typedef enum logic [3:0] {
    EXS_CAUSE_ACCESS  = 4'h0,
    EXS_CAUSE_ADDRESS = 4'h1,
    EXS_CAUSE_ILLEGAL = 4'h2,
    EXS_CAUSE_PRIV    = 4'h3,
    EXS_CAUSE_TRACE   = 4'h4,
    EXS_CAUSE_LINE_A  = 4'h5,
    EXS_CAUSE_LINE_F  = 4'h6,
    EXS_CAUSE_DEBUG   = 4'h7,
    EXS_CAUSE_FORMAT  = 4'h8,
    EXS_CAUSE_TRAP    = 4'h9,
    EXS_CAUSE_IRQ     = 4'hA
  } exs_cause_t;

  // kind of bus cycle requested
  typedef enum logic [1:0] {
    EXS_BUS_READ  = 2'h0,
    EXS_BUS_WRITE = 2'h1,
    EXS_BUS_INTERRUPT_ACK_CYCLE  = 2'h2,
    EXS_BUS_FETCH = 2'h3
  } exs_bus_t;

  typedef enum logic [2:0] {
    EXS_ST_IDLE  = 3'h0,
    EXS_ST_INTERRUPT_ACK_CYCLE  = 3'h1,
    EXS_ST_PUSH0 = 3'h2,
    EXS_ST_PUSH1 = 3'h3,
    EXS_ST_VEC   = 3'h4,
    EXS_ST_FETCH = 3'h5,
    EXS_ST_GUARD = 3'h6
  } exs_state_t;

endpackage

//--- src/exs_irq_gate.sv
/*
  interrupt request gate: masks levels at or below the mask except an
  edge of level seven, and holds sampling off while blocked.
  assumes irq_level is already synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module exs_irq_gate (
  input wire logic clk_sys, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic [2:0] irq_level, // requested level, 0 none
  input wire logic [2:0] mask_level, // current priority mask
  input wire logic block, // sampling inhibited
  input wire logic take, // request consumed
  output logic pend, // a request may be taken
  output logic [2:0] pend_level // its level
);
  logic lvl7_ff;
  logic nmi_ff;
  logic nxt_nmi;
  wire is7 = (irq_level == 3'h7);
  wire edge7 = is7 && !lvl7_ff;
  wire above = (irq_level > mask_level);

  // at mask seven, level seven counts only on its rising edge; that edge is kept until
  // serviced so a blocked handler start does not lose it
  // a take in the edge's own cycle serves that edge, so it is not kept
  assign nxt_nmi = (edge7 | nmi_ff) & ~take;
  assign pend = !block && (nmi_ff || above);
  assign pend_level = nmi_ff ? 3'h7 : irq_level;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lvl7_ff <= 1'b0;
      nmi_ff <= 1'b0;
    end else begin
      lvl7_ff <= is7;
      nmi_ff <= nxt_nmi;
    end
  end
endmodule

`default_nettype wire

//--- sim/exs_seq_properties.sv
/*
  port assertions for the exception entry sequencer.
  assumes one clock domain; bound into exs_seq at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module exs_seq_properties
  import exs_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset, low
  input wire logic exc_req, // fault pending
  input wire logic insn_done, // insn retired
  input wire logic bus_done, // cycle done
  input wire logic [15:0] processor_status_word, // live status
  input wire logic [31:0] system_stack_pointer, // live sp
  input wire logic [31:0] vector_table_base, // table base
  input wire logic exc_ack, // accepted
  input wire logic exc_busy, // active
  input wire logic bus_req, // request
  input wire exs_pkg::exs_bus_t bus_kind, // kind
  input wire logic [31:0] bus_addr, // address
  input wire logic [31:0] bus_wdata, // write data
  input wire logic psw_we, // status load
  input wire logic [15:0] psw_new, // new status
  input wire logic [15:0] psw_saved, // saved status
  input wire logic sp_we, // sp load
  input wire logic [31:0] sp_new, // new sp
  input wire logic pc_we, // pc load
  input wire logic [31:0] pc_new, // new pc
  input wire logic exc_done // finished
);
  logic [31:0] sp_ff, vbr_ff, fetch_ff, lo_w;
  assign lo_w = {sp_ff[31:2], 2'h0} - 32'h8;
  // entry values freeze once busy, so later checks see what was taken
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sp_ff <= 32'h0;
      vbr_ff <= 32'h0;
      fetch_ff <= 32'h0;
    end else begin
      if (!exc_busy) sp_ff <= system_stack_pointer;
      if (!exc_busy) vbr_ff <= vector_table_base;
      if (bus_req && bus_kind == EXS_BUS_FETCH) fetch_ff <= bus_addr;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_fetch_end;
    bus_req && bus_kind == EXS_BUS_FETCH && bus_done;
  endsequence
  sequence s_quiet;
    (!insn_done && !exc_req) [*6];
  endsequence
  AST_ACK_WRITE: assert property (exc_ack |-> psw_we && bus_req && bus_kind == EXS_BUS_WRITE)
    else $error("fault entry did not start with a frame write");
  AST_PSW_SUPER: assert property (psw_we |-> psw_new[13] && !psw_new[15])
    else $error("supervisor or trace bit wrong");
  AST_PSW_COPY: assert property (psw_we |-> psw_saved == $past(processor_status_word))
    else $error("saved status word differs");
  AST_INTERRUPT_ACK_CYCLE_ADDR: assert property (bus_req && bus_kind == EXS_BUS_INTERRUPT_ACK_CYCLE |->
    bus_addr[31:5] == 27'h7FFFFFF && bus_addr[1:0] == 2'h0 && bus_addr[4:2] != 3'h0)
    else $error("acknowledge address wrong");
  AST_INTERRUPT_ACK_CYCLE_MASK: assert property (psw_we && bus_req && bus_kind == EXS_BUS_INTERRUPT_ACK_CYCLE |->
    !psw_new[12] && psw_new[10:8] == bus_addr[4:2])
    else $error("interrupt status word wrong");
  AST_FRAME_ADDR: assert property (bus_req && bus_kind == EXS_BUS_WRITE |->
    bus_addr == lo_w || bus_addr == lo_w + 32'h4)
    else $error("frame write outside the frame");
  AST_FMT_WORD: assert property (bus_req && bus_kind == EXS_BUS_WRITE && bus_addr == lo_w |->
    bus_wdata[31:28] == 4'h4 + {2'h0, sp_ff[1:0]} && bus_wdata[15:0] == psw_saved)
    else $error("format word wrong");
  AST_SP_NEW: assert property (sp_we |-> sp_new == lo_w)
    else $error("handler stack pointer wrong");
  AST_VEC_READ: assert property (bus_req && bus_kind == EXS_BUS_READ |->
    bus_addr[31:20] == vbr_ff[31:20] && bus_addr[19:10] == 10'h0 && bus_addr[1:0] == 2'h0)
    else $error("vector read address wrong");
  AST_FETCH_END: assert property (s_fetch_end |-> ##[1:2] (exc_done && pc_we && pc_new == fetch_ff))
    else $error("no finish after handler fetch");
  AST_GUARD: assert property (exc_done ##1 s_quiet |-> !bus_req)
    else $error("interrupt taken in first handler insn");
endmodule
bind exs_seq exs_seq_properties i_props (.*);
`default_nettype wire

//--- sim/exs_bus_model.sv
/*
  system bus and interrupting peripheral behind the sequencer.
  assumes bus_req holds until the edge after bus_done.
*/
`timescale 1ns/1ps
`default_nettype none
module exs_bus_model
  import exs_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset, low
  input wire logic bus_req, // request
  input wire exs_pkg::exs_bus_t bus_kind, // kind
  input wire logic [31:0] bus_addr, // address
  input wire logic [1:0] wait_cyc, // wait states
  input wire logic [7:0] irq_vec, // vector to return
  output logic bus_done, // one-cycle done
  output logic [31:0] bus_rdata // valid with done
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 2'h0;
      bus_done <= 1'b0;
      bus_rdata <= 32'h0;
    end else if (bus_done) begin
      bus_done <= 1'b0;
      cnt_ff <= 2'h0;
      bus_rdata <= ~bus_rdata;
    end else if (bus_req && cnt_ff == wait_cyc) begin
      bus_done <= 1'b1;
      // vector in low byte, upper three bytes noise
      bus_rdata <= (bus_kind == EXS_BUS_INTERRUPT_ACK_CYCLE) ? {24'hA5A5A5, irq_vec} : bus_addr + 32'h0001_0000;
    end else if (bus_req) begin
      cnt_ff <= cnt_ff + 2'h1;
    end else begin
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule
`default_nettype wire

//--- sim/exs_seq_test.sv
/*
  self-checking bench for the exception entry sequencer.
  assumes exs_bus_model answers reads with address plus 10000h.
*/
`timescale 1ns/1ps
`default_nettype none
module exs_seq_test;
  import exs_pkg::*;
  logic clk_sys, rst_b, exc_req, insn_boundary, insn_done, bus_done;
  logic exc_ack, exc_busy, bus_req, psw_we, sp_we, pc_we, exc_done;
  exs_cause_t exc_cause;
  exs_bus_t bus_kind;
  logic [3:0] exc_trap_num, exc_fault_code, fs_e;
  logic [2:0] irq_pin;
  logic [1:0] wait_cyc;
  logic [7:0] irq_vec;
  logic [15:0] processor_status_word, psw_new, psw_saved, got_psw;
  logic [31:0] pc_fault, pc_next, system_stack_pointer, vector_table_base, bus_rdata;
  logic [31:0] bus_addr, bus_wdata, sp_new, pc_new, got_sp, got_pc;
  logic [65:0] lq[$];
  int n_errors, n_tests, cyc, i;
  logic [7:0] vz[10] = '{8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h2F};
  logic [3:0] fcz[5] = '{4'h4, 4'h8, 4'h9, 4'hC, 4'h5};
  logic [9:0] fault_pc = 10'h16F;
  exs_seq i_dut (.*);
  exs_bus_model i_bus (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (bus_req && bus_done) lq.push_back({bus_kind, bus_addr, bus_wdata});
    if (psw_we) got_psw <= psw_new;
    if (sp_we) got_sp <= sp_new;
    if (pc_we) got_pc <= pc_new;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [65:0] got, input logic [65:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic entry(input logic irq, input logic [2:0] lvl, input int c, input logic [3:0] fc,
    input logic [31:0] sp, input logic [7:0] vec, input logic use_f, input logic [3:0] fs);
    logic [31:0] lo, va;
    logic [15:0] ep;
    int k;
    lo = {sp[31:2], 2'h0} - 32'h8;
    va = {vector_table_base[31:20], 20'h0} + {22'h0, vec, 2'h0};
    ep = processor_status_word;
    ep[15] = 1'b0;
    ep[13] = 1'b1;
    system_stack_pointer = sp;
    lq.delete();
    if (irq) begin
      ep[12] = 1'b0;
      ep[10:8] = lvl;
      irq_vec = vec;
      irq_pin = lvl;
    end else begin
      exc_cause = exs_cause_t'(c[3:0]);
      exc_trap_num = vec[3:0];
      exc_fault_code = fc;
      exc_req = 1'b1;
    end
    for (k = 0; k < 300 && exc_done !== 1'b1; k++) begin
      tick();
      if (exc_ack === 1'b1) exc_req = 1'b0;
    end
    tick();
    k = irq ? 1 : 0;
    chk(lq.size(), 4 + k);
    if (irq) chk(lq[0][65:32], {EXS_BUS_INTERRUPT_ACK_CYCLE, 32'hFFFF_FFE0 | {27'h0, lvl, 2'h0}});
    chk(lq[k], {EXS_BUS_WRITE, lo, 4'h4 + {2'h0, sp[1:0]}, fs, vec, processor_status_word});
    chk(lq[k + 1], {EXS_BUS_WRITE, lo + 32'h4, use_f ? pc_fault : pc_next});
    chk(lq[k + 2][65:32], {EXS_BUS_READ, va});
    chk(lq[k + 3][65:32], {EXS_BUS_FETCH, va + 32'h0001_0000});
    chk(got_psw, ep);
    chk(psw_saved, processor_status_word);
    chk(got_sp, lo);
    chk(got_pc, va + 32'h0001_0000);
  endtask
  initial begin
    rst_b = 1'b0;
    exc_req = 1'b0;
    exc_cause = EXS_CAUSE_ACCESS;
    exc_trap_num = 4'h0;
    exc_fault_code = 4'h0;
    pc_fault = 32'h0000_4010;
    pc_next = 32'h0000_4016;
    processor_status_word = 16'h9705;
    system_stack_pointer = 32'h0002_0000;
    vector_table_base = 32'h0ABC_DEF0;
    irq_pin = 3'h0;
    insn_boundary = 1'b0;
    insn_done = 1'b0;
    wait_cyc = 2'h0;
    irq_vec = 8'h00;
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) tick();
    rst_b = 1'b1;
    for (i = 0; i < 10; i++) begin
      wait_cyc = i[1:0];
      fs_e = (i < 2 && fcz[i % 5] != 4'h5) ? fcz[i % 5] : 4'h0;
      entry(0, 3'h0, i, fcz[i % 5], 32'h0002_0100 + i, vz[i], fault_pc[i], fs_e);
    end
    for (i = 0; i < 5; i++) begin
      fs_e = (fcz[i] == 4'h5) ? 4'h0 : fcz[i];
      entry(0, 3'h0, 0, fcz[i], 32'h0003_FFFC, 8'h02, 1'b1, fs_e);
    end
    processor_status_word = 16'h9205;
    insn_boundary = 1'b1;
    irq_pin = 3'h2;
    // retire the last handler's first instruction so interrupts are sampled again
    insn_done = 1'b1;
    tick();
    insn_done = 1'b0;
    repeat (10) tick();
    chk(exc_busy, 1'b0);
    wait_cyc = 2'h3;
    entry(1, 3'h3, 10, 4'h0, 32'h0001_0003, 8'hFF, 1'b0, 4'h0);
    repeat (8) tick();
    chk(bus_req, 1'b0);
    insn_done = 1'b1;
    tick();
    insn_done = 1'b0;
    entry(1, 3'h3, 10, 4'h0, 32'h0001_0002, 8'h40, 1'b0, 4'h0);
    irq_pin = 3'h0;
    processor_status_word = 16'h2700;
    repeat (3) tick();
    insn_done = 1'b1;
    tick();
    insn_done = 1'b0;
    entry(1, 3'h7, 10, 4'h0, 32'h0001_0001, 8'h1F, 1'b0, 4'h0);
    insn_done = 1'b1;
    tick();
    insn_done = 1'b0;
    repeat (10) tick();
    chk(exc_busy, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
